//--- iprv_pkg.sv
// Purpose: shared constants of the interrupt priority vector resolver
// Assumes: 32-bit register bus, one word per register
// Notes:   vector table is indexed by fixed-priority slot, 0 highest
package iprv_pkg;

  localparam int          SRC_N       = 17;
  localparam int          AXI_AW      = 8;

  // register offsets and field positions
  localparam logic [7:0]  OFS_PRIO    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam int          BIT_BOOT    = 7;
  localparam int          BIT_SPECIAL = 6;
  localparam int          BIT_MODEA   = 5;
  localparam logic [4:0]  PSEL_RESET  = 5'h06;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // mode capture sequencing after reset release
  localparam logic [1:0]  CAP_SETTLE  = 2'h2;
  localparam logic [1:0]  CAP_DONE    = 2'h3;

  // fixed-priority slot indices
  localparam logic [4:0]  IDX_IRQ     = 5'h00;
  localparam logic [4:0]  IDX_SER2    = 5'h0a;
  localparam logic [4:0]  IDX_SER3    = 5'h0b;
  localparam logic [4:0]  IDX_SER1    = 5'h10;

  // priority-select codes
  localparam logic [4:0]  CODE_IRQ    = 5'h06;
  localparam logic [4:0]  CODE_TICK   = 5'h07;
  localparam logic [4:0]  CODE_CAP1   = 5'h08;
  localparam logic [4:0]  CODE_CAP4   = 5'h0f;
  localparam logic [4:0]  CODE_TOF    = 5'h10;
  localparam logic [4:0]  CODE_SHIFT  = 5'h13;
  localparam logic [4:0]  CODE_SER1   = 5'h14;
  localparam logic [4:0]  CODE_SER2   = 5'h15;
  localparam logic [4:0]  CODE_SER3   = 5'h16;

  // maskable vectors by slot
  localparam logic [15:0] VEC_TAB [0:SRC_N-1] = '{
    16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8,
    16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffd4, 16'hffd2,
    16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6};

  localparam logic [15:0] VEC_NMI     = 16'hfff4;
  localparam logic [15:0] VEC_SWI     = 16'hfff6;
  localparam logic [15:0] VEC_ILL     = 16'hfff8;
  localparam logic [15:0] VEC_COP     = 16'hfffa;
  localparam logic [15:0] VEC_CLKMON  = 16'hfffc;
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] BOOT_LO     = 16'hbe40;
  localparam logic [15:0] BOOT_HI     = 16'hbfff;

endpackage : iprv_pkg

//--- iprv_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to aclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module iprv_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= INIT;
      dout   <= INIT;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : iprv_sync

//--- iprv_axil.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register decode done by the parent from wr_addr and rd_addr
// Notes:   write fires in the first cycle that both address and data are held
`timescale 1ns/1ps
module iprv_axil
  import iprv_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write channels
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // read channels
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // register side
  output logic                   wr_fire,
  output logic [AXI_AW-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  output logic [AXI_AW-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);

  assign wr_fire = !awready && !wready && !bvalid;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_ok ? rd_data : 32'h0;
      rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : iprv_axil

//--- iprv_top.sv
// Purpose: interrupt priority resolver and vector supplier
// Assumes: peripheral flags and enables on aclk; pins asynchronous
// Notes:   vector is latched on service_start, valid for one cycle
`timescale 1ns/1ps

// Notes on behaviour
// - default maskable ranking, external pin first
// - priority code lifts one source to top
// - promoted source still obeys all masks
// - promotion never changes any vector
// - priority code writable only while masked
// - mode bits writable only in special mode
// - boot rom mapped at be40..bfff when on
// - special-mode bit selects special variation
// - mode-a bit selects expanded or test mode
// - code to source mapping of priority field
// - unassigned codes promote the external pin
// - serial unit 3 five causes share ffd2
// - serial unit 2 five causes share ffd4
// - shift, pulse, overflow vectors ffd8..ffde
// - timer, tick and pin vectors ffe0..fff2
// - nonmaskable and reset vectors fff4..fffe
// - priority code resets to external pin
// - mode bits captured from mode pins at reset
// - fixed order of non-maskable sources
// - supply winner vector when servicing begins
module iprv_top
  import iprv_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // register bus
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pins
  input  wire logic              irq_pin_n,
  input  wire logic              nonmaskable_pin_int_n,
  input  wire logic              mode_pin_a,
  input  wire logic              mode_pin_b,
  // cpu mask bits
  input  wire logic              global_mask_bit,
  input  wire logic              nonmaskable_mask_bit,
  // single-cause peripherals, indexed by slot
  input  wire logic [SRC_N-1:0]  periph_flag,
  input  wire logic [SRC_N-1:0]  periph_en,
  // serial units: flags {idle,tx_done,tx_empty,overrun,rx_full}
  input  wire logic [4:0]        serial1_flags,
  input  wire logic [3:0]        serial1_enables,
  input  wire logic [4:0]        serial2_flags,
  input  wire logic [3:0]        serial2_enables,
  input  wire logic [4:0]        serial3_flags,
  input  wire logic [3:0]        serial3_enables,
  // non-maskable causes
  input  wire logic              power_on_reset,
  input  wire logic              clock_fail,
  input  wire logic              clock_monitor_enable,
  input  wire logic              cop_timeout,
  input  wire logic              watchdog_disable_option,
  input  wire logic              illegal_op_req,
  input  wire logic              swi_req,
  // cpu side
  input  wire logic              service_start,
  input  wire logic [15:0]       fetch_addr,
  output logic [15:0]            vector_addr,
  output logic                   vector_valid,
  output logic                   int_pending,
  output logic                   boot_rom_sel,
  // mode bits
  output logic                   bootstrap_rom_on,
  output logic                   special_mode_bit,
  output logic                   mode_a_bit
);

  logic [4:0]        psel;
  logic [1:0]        cap_cnt;
  logic [4:0]        win_q;
  logic              irq_s_n;
  logic              nmi_s_n;
  logic [1:0]        mode_s;
  logic              wr_fire;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [AXI_AW-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [SRC_N-1:0]  req;
  logic [SRC_N-1:0]  mreq;
  logic [4:0]        prom;
  logic [4:0]        next_win;
  logic [15:0]       next_vector;
  logic              nm_any;
  logic              next_any;

  // ---------------------------------------------------------------
  // helpers

  function automatic logic ser_req(input logic [4:0] f, input logic [3:0] e);
    ser_req = ((f[0] || f[1]) && e[0]) || (f[2] && e[1]) ||
              (f[3] && e[2]) || (f[4] && e[3]);
  endfunction : ser_req

  function automatic logic [4:0] psel_to_idx(input logic [4:0] c);
    if (c == CODE_IRQ)
      psel_to_idx = IDX_IRQ;
    else if (c == CODE_TICK)
      psel_to_idx = 5'h01;
    else if (c >= CODE_CAP1 && c <= CODE_CAP4)
      psel_to_idx = c - 5'h06;
    else if (c >= CODE_TOF && c <= CODE_SHIFT)
      psel_to_idx = c - 5'h04;
    else if (c == CODE_SER1)
      psel_to_idx = IDX_SER1;
    else if (c == CODE_SER2)
      psel_to_idx = IDX_SER2;
    else if (c == CODE_SER3)
      psel_to_idx = IDX_SER3;
    else
      psel_to_idx = IDX_IRQ;
  endfunction : psel_to_idx

  function automatic logic reg_is(input logic [AXI_AW-1:0] a, input logic [7:0] ofs);
    reg_is = (a == ofs);
  endfunction : reg_is

  // ---------------------------------------------------------------
  // submodules

  iprv_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({irq_pin_n, nonmaskable_pin_int_n}),
    .dout    ({irq_s_n, nmi_s_n})
  );

  iprv_sync #(.W(2), .INIT(2'h0)) u_mode_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({mode_pin_b, mode_pin_a}),
    .dout    (mode_s)
  );

  iprv_axil u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_fire (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ---------------------------------------------------------------
  // register decode

  assign wr_ok = reg_is(wr_addr, OFS_PRIO) || reg_is(wr_addr, OFS_STATUS);
  assign rd_ok = reg_is(rd_addr, OFS_PRIO) || reg_is(rd_addr, OFS_STATUS);

  always_comb begin
    if (reg_is(rd_addr, OFS_PRIO))
      rd_data = {24'h0, bootstrap_rom_on, special_mode_bit, mode_a_bit, psel};
    else if (reg_is(rd_addr, OFS_STATUS))
      rd_data = {23'h0, int_pending, 3'h0, win_q};
    else
      rd_data = 32'h0;
  end

  // reset to external pin; gated by mask
  always_ff @(posedge aclk) begin
    if (!aresetn)
      psel <= PSEL_RESET;
    else if (wr_fire && reg_is(wr_addr, OFS_PRIO) && wr_strb[0] && global_mask_bit)
      psel <= wr_data[4:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cap_cnt <= 2'h0;
    else if (cap_cnt != CAP_DONE)
      cap_cnt <= cap_cnt + 2'h1;
  end

  // capture pins after release, special-mode writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bootstrap_rom_on <= 1'b0;
      special_mode_bit <= 1'b0;
      mode_a_bit       <= 1'b0;
    end else if (cap_cnt == CAP_SETTLE) begin
      bootstrap_rom_on <= !mode_s[1] && !mode_s[0];
      special_mode_bit <= !mode_s[1];
      mode_a_bit       <= mode_s[0];
    end else if (cap_cnt == CAP_DONE && wr_fire && reg_is(wr_addr, OFS_PRIO) &&
                 wr_strb[0] && special_mode_bit) begin
      bootstrap_rom_on <= wr_data[BIT_BOOT];
      special_mode_bit <= wr_data[BIT_SPECIAL];
      mode_a_bit       <= wr_data[BIT_MODEA];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      boot_rom_sel <= 1'b0;
    else
      boot_rom_sel <= bootstrap_rom_on && fetch_addr >= BOOT_LO && fetch_addr <= BOOT_HI;
  end

  // ---------------------------------------------------------------
  // arbitration

  always_comb begin
    req = periph_flag & periph_en;
    req[IDX_IRQ]  = !irq_s_n;
    req[IDX_SER2] = ser_req(serial2_flags, serial2_enables);
    req[IDX_SER3] = ser_req(serial3_flags, serial3_enables);
    req[IDX_SER1] = ser_req(serial1_flags, serial1_enables);
  end

  assign mreq = global_mask_bit ? '0 : req;
  assign prom = psel_to_idx(psel);

  always_comb begin
    next_win = 5'h0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (mreq[i])
        next_win = 5'(i);
    end
    if (mreq[prom])
      next_win = prom;
  end

  always_comb begin
    nm_any      = 1'b1;
    next_vector = VEC_RESET;
    if (power_on_reset)
      next_vector = VEC_RESET;
    else if (clock_fail && clock_monitor_enable)
      next_vector = VEC_CLKMON;
    else if (cop_timeout && !watchdog_disable_option)
      next_vector = VEC_COP;
    else if (!nmi_s_n && !nonmaskable_mask_bit)
      next_vector = VEC_NMI;
    else if (illegal_op_req)
      next_vector = VEC_ILL;
    else if (swi_req)
      next_vector = VEC_SWI;
    else begin
      nm_any      = 1'b0;
      next_vector = VEC_TAB[next_win];
    end
  end

  assign next_any = nm_any || (|mreq);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_addr  <= VEC_RESET;
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= service_start && next_any;
      if (service_start && next_any)
        vector_addr <= next_vector;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_pending <= 1'b0;
      win_q       <= 5'h0;
    end else begin
      int_pending <= next_any;
      win_q       <= next_win;
    end
  end

  // ---------------------------------------------------------------
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_vector_a: assert property (service_start && power_on_reset |=> vector_addr == VEC_RESET)
    else $error("reset vector not supplied");
  clkmon_order_a: assert property (service_start && !power_on_reset && clock_fail && clock_monitor_enable
      |=> vector_valid && vector_addr == VEC_CLKMON)
    else $error("clock monitor order wrong");
  cop_gate_a: assert property (service_start && watchdog_disable_option && !power_on_reset &&
      !(clock_fail && clock_monitor_enable) |=> vector_addr != VEC_COP || $past(vector_addr) == VEC_COP)
    else $error("watchdog vector despite disable");
  psel_lock_a: assert property (!global_mask_bit |=> $stable(psel))
    else $error("priority field written while unmasked");
  mode_lock_a: assert property (cap_cnt == CAP_DONE && !special_mode_bit
      |=> $stable({bootstrap_rom_on, special_mode_bit, mode_a_bit}))
    else $error("mode bits changed outside special mode");
  psel_reset_a: assert property (cap_cnt == 2'h0 |-> psel == PSEL_RESET)
    else $error("priority field reset value wrong");
  promote_win_a: assert property (service_start && !nm_any && mreq[prom]
      |=> vector_valid && vector_addr == VEC_TAB[$past(prom)])
    else $error("promoted source did not win");
  mask_block_a: assert property (service_start && global_mask_bit && !nm_any |=> !vector_valid)
    else $error("masked source was serviced");
  boot_map_a: assert property (boot_rom_sel |-> $past(bootstrap_rom_on) &&
      $past(fetch_addr) >= BOOT_LO && $past(fetch_addr) <= BOOT_HI)
    else $error("boot rom selected outside window");
  reserved_code_a: assert property (psel >= 5'h17 || psel <= 5'h05 |-> prom == IDX_IRQ)
    else $error("reserved code did not select pin");

endmodule : iprv_top

//--- iprv_cpu_model.sv
// Purpose: cpu-side partner of the resolver: mask bits, service pulse, vector capture
// Assumes: go is a one-cycle pulse from the bench, masks follow bench levels
// Notes:   both masks come out of reset set, as the cpu does
`timescale 1ns/1ps
module iprv_cpu_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // bench control
  input  wire logic        go,
  input  wire logic        i_req,
  input  wire logic        x_req,
  output logic             hit,
  output logic [15:0]      got,
  // resolver side
  output logic             service_start,
  output logic             global_mask_bit,
  output logic             nonmaskable_mask_bit,
  input  wire logic        vector_valid,
  input  wire logic [15:0] vector_addr
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_mask_bit      <= 1'b1;
      nonmaskable_mask_bit <= 1'b1;
    end else begin
      global_mask_bit      <= i_req;
      nonmaskable_mask_bit <= x_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      service_start <= 1'b0;
      hit           <= 1'b0;
      got           <= 16'h0000;
    end else begin
      service_start <= go;
      if (go) begin
        hit <= 1'b0;
      end else if (vector_valid) begin
        hit <= 1'b1;
        got <= vector_addr;
      end
    end
  end
endmodule : iprv_cpu_model

//--- tb_interrupt_priority_vector_resolver.sv
// Purpose: self-checking bench of the resolver top
// Assumes: straps both low at reset, so boot rom and special mode come up on
// Notes:   every scenario is a task that judges its own results
`timescale 1ns/1ps
module tb_interrupt_priority_vector_resolver import iprv_pkg::*;;
  logic        aclk, aresetn, go, i_req, x_req, hit, service_start, global_mask_bit, nonmaskable_mask_bit;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, serial1_enables, serial2_enables, serial3_enables;
  logic [1:0]  bresp, rresp, r;
  logic        irq_pin_n, nonmaskable_pin_int_n, mode_pin_a, mode_pin_b, power_on_reset, clock_fail;
  logic        clock_monitor_enable, cop_timeout, watchdog_disable_option, illegal_op_req, swi_req;
  logic        vector_valid, int_pending, boot_rom_sel, bootstrap_rom_on, special_mode_bit, mode_a_bit;
  logic [16:0] periph_flag, periph_en;
  logic [4:0]  serial1_flags, serial2_flags, serial3_flags;
  logic [15:0] fetch_addr, vector_addr, got;
  int          n_mismatch, check_count;
  logic [15:0] vt [17] = '{16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4,
                           16'hffe2, 16'hffe0, 16'hffd4, 16'hffd2, 16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6};

  iprv_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_pin_n,
    .nonmaskable_pin_int_n, .mode_pin_a, .mode_pin_b, .global_mask_bit, .nonmaskable_mask_bit, .periph_flag,
    .periph_en, .serial1_flags, .serial1_enables, .serial2_flags, .serial2_enables, .serial3_flags,
    .serial3_enables, .power_on_reset, .clock_fail, .clock_monitor_enable, .cop_timeout, .watchdog_disable_option,
    .illegal_op_req, .swi_req, .service_start, .fetch_addr, .vector_addr, .vector_valid, .int_pending,
    .boot_rom_sel, .bootstrap_rom_on, .special_mode_bit, .mode_a_bit);

  iprv_cpu_model cpu (.aclk, .aresetn, .go, .i_req, .x_req, .hit, .got, .service_start, .global_mask_bit,
    .nonmaskable_mask_bit, .vector_valid, .vector_addr);

  always #2.5 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    q = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // slot flags; serial slots raise their receive-full cause
  task automatic pend(input logic [16:0] m);
    periph_flag   <= m;
    irq_pin_n     <= ~m[0];
    serial2_flags <= {4'h0, m[10]};
    serial3_flags <= {4'h0, m[11]};
    serial1_flags <= {4'h0, m[16]};
  endtask : pend

  // settle pins through the syncs, then one service request
  task automatic svc(input logic [15:0] e, input logic h, input string n);
    repeat (4) @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({n, " hit"}, hit, h);
    if (h) chk(n, got, e);
    chk({n, " pending"}, int_pending, h);
  endtask : svc

  function automatic int slot_of(input int c);
    if (c >= 7 && c <= 15) return c - 6;
    if (c >= 16 && c <= 19) return c - 4;
    if (c == 20) return 16;
    if (c == 21) return 10;
    if (c == 22) return 11;
    return 0;
  endfunction : slot_of

  task automatic t_reset;
    rd(OFS_PRIO, d, r);
    chk("psel reset", d[4:0], 5'h06);
    chk("mode reset", d[7:5], 3'b110);
    chk("mode ports", {bootstrap_rom_on, special_mode_bit, mode_a_bit}, 3'b110);
    for (int i = 0; i < 4; i++) begin
      fetch_addr <= (i == 0) ? 16'hbe3f : (i == 1) ? 16'hbe40 : (i == 2) ? 16'hbfff : 16'hc000;
      repeat (2) @(posedge aclk);
      chk("boot window", boot_rom_sel, i == 1 || i == 2);
    end
    rd(8'h08, d, r);
    chk("unmapped rresp", r, RESP_SLVERR);
    chk("unmapped rdata", d, 0);
    wr(8'h0c, 0, r);
    chk("unmapped bresp", r, RESP_SLVERR);
    $display("test reset and bus done");
  endtask : t_reset

  task automatic t_order;
    i_req <= 1'b0;
    for (int s = 0; s < 17; s++) begin
      pend(17'h1ffff << s);
      svc(vt[s], 1'b1, "default order");
    end
    pend(17'h0);
    svc(16'h0, 1'b0, "none pending");
    for (int c = 0; c < 32; c++) begin
      i_req <= 1'b1;
      wr(OFS_PRIO, 32'hc0 | c, r);
      i_req <= 1'b0;
      pend(17'h1ffff);
      svc(vt[slot_of(c)], 1'b1, "promoted");
      pend(17'h1c000);
      svc(vt[(slot_of(c) >= 14) ? slot_of(c) : 14], 1'b1, "rest order");
    end
    $display("test order done");
  endtask : t_order

  task automatic t_mask;
    i_req <= 1'b1;
    wr(OFS_PRIO, 32'hcb, r);
    i_req <= 1'b0;
    pend(17'h01020);
    periph_en <= 17'h1ffdf;
    svc(vt[12], 1'b1, "local enable");
    periph_en <= 17'h1ffff;
    svc(vt[5], 1'b1, "promoted enabled");
    rd(OFS_STATUS, d, r);
    chk("status word", d, 32'h105);
    i_req <= 1'b1;
    svc(16'h0, 1'b0, "global mask");
    i_req <= 1'b0;
    wr(OFS_PRIO, 32'hd0, r);
    rd(OFS_PRIO, d, r);
    chk("psel guarded", d[4:0], 5'h0b);
    $display("test mask done");
  endtask : t_mask

  task automatic t_serial;
    logic [15:0] sv [3] = '{16'hffd6, 16'hffd4, 16'hffd2};
    logic [3:0]  en;
    pend(17'h0);
    for (int u = 0; u < 3; u++)
      for (int c = 0; c < 5; c++)
        for (int e = 0; e < 2; e++) begin
          en = e ? 4'hf : ~(4'h1 << ((c < 2) ? 0 : c - 1));
          serial1_flags   <= (u == 0) ? 5'h01 << c : 5'h0;
          serial2_flags   <= (u == 1) ? 5'h01 << c : 5'h0;
          serial3_flags   <= (u == 2) ? 5'h01 << c : 5'h0;
          serial1_enables <= (u == 0) ? en : 4'hf;
          serial2_enables <= (u == 1) ? en : 4'hf;
          serial3_enables <= (u == 2) ? en : 4'hf;
          svc(sv[u], e[0], "serial cause");
        end
    $display("test serial done");
  endtask : t_serial

  task automatic t_nmi;
    logic [15:0] nv [7] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff4, 16'hfff8, 16'hfff6, 16'hfff2};
    pend(17'h00001);
    for (int k = 0; k < 7; k++) begin
      power_on_reset          <= k < 1;
      clock_fail              <= 1'b1;
      clock_monitor_enable    <= k < 2;
      cop_timeout             <= 1'b1;
      watchdog_disable_option <= k >= 3;
      x_req                   <= k >= 4;
      nonmaskable_pin_int_n   <= 1'b0;
      illegal_op_req          <= k < 5;
      swi_req                 <= k < 6;
      svc(nv[k], 1'b1, "nonmaskable order");
    end
    clock_fail            <= 1'b0;
    cop_timeout           <= 1'b0;
    nonmaskable_pin_int_n <= 1'b1;
    $display("test nonmaskable done");
  endtask : t_nmi

  task automatic t_mode;
    i_req <= 1'b1;
    wr(OFS_PRIO, 32'h66, r);
    rd(OFS_PRIO, d, r);
    chk("mode write special", d[7:0], 8'h66);
    chk("mode ports", {bootstrap_rom_on, special_mode_bit, mode_a_bit}, 3'b011);
    fetch_addr <= 16'hbe40;
    repeat (2) @(posedge aclk);
    chk("boot off", boot_rom_sel, 1'b0);
    wr(OFS_PRIO, 32'h06, r);
    wr(OFS_PRIO, 32'he6, r);
    rd(OFS_PRIO, d, r);
    chk("mode write normal", d[7:0], 8'h06);
    // second reset with both straps high: normal mode, boot rom off
    mode_pin_a <= 1'b1;
    mode_pin_b <= 1'b1;
    aresetn    <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn    <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("strap normal", {bootstrap_rom_on, special_mode_bit, mode_a_bit}, 3'b001);
    chk("vector reset", vector_addr, 16'hfffe);
    $display("test mode done");
  endtask : t_mode

  initial begin
    aclk = 0;
    aresetn = 0;
    {go, awvalid, wvalid, bready, arvalid, rready, mode_pin_a, mode_pin_b} = '0;
    {i_req, x_req, irq_pin_n, nonmaskable_pin_int_n, watchdog_disable_option} = '1;
    {power_on_reset, clock_fail, clock_monitor_enable, cop_timeout, illegal_op_req, swi_req} = '0;
    {awaddr, araddr, wdata, fetch_addr, periph_flag} = '0;
    {serial1_flags, serial2_flags, serial3_flags} = '0;
    {serial1_enables, serial2_enables, serial3_enables, wstrb} = '1;
    periph_en = '1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_reset;
    t_order;
    t_mask;
    t_serial;
    t_nmi;
    t_mode;
    conclude;
  end

  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule : tb_interrupt_priority_vector_resolver
